// [inc/pes_pkg.sv]
`default_nettype none
package pes_pkg;

    // ----------------------------------------
    // Register indices, byte address is index times four
    // ----------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_PEAK_CAP = 16'he501;
    localparam logic [15:0] IDX_STATUS = 16'he502;
    localparam logic [15:0] IDX_MASK = 16'he510;
    localparam logic [15:0] IDX_PULSE_MODE = 16'he511;
    localparam logic [15:0] IDX_MEAS_MODE = 16'he512;
    localparam logic [15:0] IDX_SIGN = 16'he513;
    localparam logic [15:0] IDX_HALF_CYC = 16'he514;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int PEAK_VAL_W = 24;
    localparam int PEAK_TAG_LSB = 24;
    localparam int STATUS_W = 19;
    localparam int ST_LINE_DONE = 5;
    localparam int ST_ACT_REV_LSB = 6;
    localparam int ST_SUM_ONE = 9;
    localparam int ST_REACT_REV_LSB = 10;
    localparam int ST_SUM_TWO = 13;
    localparam int ST_PULSE_LSB = 14;
    localparam int ST_DONE = 17;
    localparam int ST_SUM_THREE = 18;
    localparam int PULSE_MODE_W = 12;
    localparam int PM_SEL_ONE_LSB = 0;
    localparam int PM_SEL_TWO_LSB = 3;
    localparam int PM_SEL_THREE_LSB = 6;
    localparam int CF_DIS_LSB = 9;
    localparam int MM_ACT_SEL = 0;
    localparam int MM_REACT_SEL = 1;
    localparam int MM_LINE_MODE = 2;
    localparam int MEAS_MODE_W = 3;
    localparam int SIGN_W = 9;
    localparam int HALF_CYC_W = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [15:0] RST_HALF_CYC = 16'hffff;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

endpackage
`default_nettype wire

// [test/peak_and_event_status_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module peak_and_event_status_regs_tb
    import pes_pkg::*;
;
    localparam int LOW = 3;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, hung;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic peak_valid, half_cycle_tick, dsp_done, p1_n, p2_n, p3_n;
    logic [23:0] peak_value, pv;
    logic [2:0] peak_phase, ast, asf, rst_, rsf;
    logic [14:0] energy_bit30;
    logic [7:0] pulse_src_req, pulse_src_sign;
    logic [32:0] q[$];
    int fail_count = 0;
    int tests_run = 0;
    int p;

    always #10 pclk = ~pclk;

    pes_regs #(.PULSE_LOW_CYCLES(LOW)) i_pes_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .peak_valid(peak_valid), .peak_value(peak_value),
        .peak_phase(peak_phase), .energy_bit30(energy_bit30), .half_cycle_tick(half_cycle_tick),
        .act_sign_total(ast), .act_sign_fund(asf), .react_sign_total(rst_), .react_sign_fund(rsf),
        .pulse_src_req(pulse_src_req), .pulse_src_sign(pulse_src_sign), .dsp_done(dsp_done),
        .pulse_output_one_n(p1_n), .pulse_output_two_n(p2_n), .pulse_output_three_n(p3_n), .irq(irq));

    pes_host_model i_pes_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .hung(hung));

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk(input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        q.push_back({1'b0, exp});
        i_pes_host_model.xfer(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        i_pes_host_model.xfer(1'b1, idx, d);
    endtask

    // Read results are checked where they appear, oldest note first
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && q.size() > 0)
            cmp(q.pop_front(), {pslverr, prdata});
    end

    always @(posedge hung)
    begin
        fail_count++;
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {peak_valid, half_cycle_tick, dsp_done, peak_value, peak_phase} = '0;
        {ast, asf, rst_, rsf, energy_bit30, pulse_src_req, pulse_src_sign} = '0;
        void'($urandom(62270));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_PEAK_CAP, 32'h0000_0000);
        rd(IDX_STATUS, 32'h0000_0000);
        rd(IDX_HALF_CYC, 32'h0000_ffff);
        q.push_back({1'b1, 32'h0000_0000});
        i_pes_host_model.xfer(1'b0, 16'h0100, 32'h0000_0000);
        pv = 24'($urandom);
        p = $urandom_range(2);
        @(posedge pclk);
        peak_valid <= 1'b1;
        peak_value <= pv;
        peak_phase <= 3'(1 << p);
        @(posedge pclk);
        peak_valid <= 1'b0;
        rd(IDX_PEAK_CAP, {5'h00, 3'(1 << p), pv});
        wr(IDX_PEAK_CAP, 32'hffff_ffff);
        rd(IDX_PEAK_CAP, {5'h00, 3'(1 << p), pv});
        for (int c = 0; c < 5; c++)
        begin
            @(posedge pclk);
            energy_bit30[3 * c + $urandom_range(2)] <= 1'b1;
            rd(IDX_STATUS, 32'(1 << c));
            wr(IDX_STATUS, 32'(1 << c));
        end
        rd(IDX_STATUS, 32'h0000_0000);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge pclk);
            ast[k] <= 1'b1;
            rst_[k] <= 1'b1;
            rd(IDX_STATUS, 32'(32'h11 << (6 + k)));
            wr(IDX_STATUS, 32'h0007_ffff);
        end
        rd(IDX_SIGN, 32'h0000_0077);
        @(posedge pclk);
        asf <= 3'b111;
        rsf <= 3'b111;
        wr(IDX_MEAS_MODE, 32'h0000_0003);
        rd(IDX_STATUS, 32'h0000_0000);
        @(posedge pclk);
        asf[1] <= 1'b0;
        rst_[1] <= 1'b0;
        rd(IDX_STATUS, 32'h0000_0080);
        rd(IDX_SIGN, 32'h0000_0075);
        @(posedge pclk);
        pulse_src_sign <= 8'h01;
        rd(IDX_STATUS, 32'h0004_2280);
        rd(IDX_SIGN, 32'h0000_01fd);
        @(posedge pclk);
        pulse_src_sign <= 8'h00;
        wr(IDX_STATUS, 32'h0007_ffff);
        wr(IDX_PULSE_MODE, 32'h0000_00d1);
        @(posedge pclk);
        pulse_src_req <= 8'h02;
        @(posedge pclk);
        pulse_src_req <= 8'h00;
        #1;
        chk(1'b0, p1_n);
        chk(1'b1, p2_n);
        chk(1'b1, p3_n);
        repeat (LOW) @(posedge pclk);
        #1;
        chk(1'b1, p1_n);
        rd(IDX_STATUS, 32'h0000_4000);
        wr(IDX_STATUS, 32'h0000_4000);
        wr(IDX_PULSE_MODE, 32'h0000_0ed1);
        @(posedge pclk);
        pulse_src_req <= 8'h0e;
        @(posedge pclk);
        pulse_src_req <= 8'h00;
        #1;
        chk(1'b1, p1_n);
        chk(1'b1, p2_n);
        chk(1'b1, p3_n);
        rd(IDX_STATUS, 32'h0001_c000);
        wr(IDX_STATUS, 32'h0007_ffff);
        @(posedge pclk);
        dsp_done <= 1'b1;
        @(posedge pclk);
        dsp_done <= 1'b0;
        #1;
        chk(1'b0, irq);
        wr(IDX_MASK, 32'h0002_0000);
        #1;
        chk(1'b1, irq);
        rd(IDX_STATUS, 32'h0002_0000);
        wr(IDX_STATUS, 32'h0002_0000);
        #1;
        chk(1'b0, irq);
        wr(IDX_HALF_CYC, 32'h0000_0003);
        wr(IDX_MEAS_MODE, 32'h0000_0007);
        for (int t = 0; t < 3; t++)
        begin
            @(posedge pclk);
            half_cycle_tick <= 1'b1;
            @(posedge pclk);
            half_cycle_tick <= 1'b0;
            rd(IDX_STATUS, (t == 2) ? 32'h0000_0020 : 32'h0000_0000);
        end
        conclude();
    end
endmodule
`default_nettype wire

// [test/pes_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pes_host_model
    import pes_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    // Raised when a slave never answers
    output logic hung
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // ----------------------------------------
    // One transfer; request held until pready is seen high, or dropped after 64 access cycles
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1)
            hung <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verilog/pes_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module pes_regs
    import pes_pkg::*;
#(
    parameter int PULSE_LOW_CYCLES = 4
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peak detector
    input wire logic peak_valid,
    input wire logic [PEAK_VAL_W-1:0] peak_value,
    input wire logic [2:0] peak_phase,
    // Energy accumulator bit 30, three phases per class, five classes
    input wire logic [14:0] energy_bit30,
    // Line cycle timing
    input wire logic half_cycle_tick,
    // Power signs from the datapath, 1 means negative
    input wire logic [2:0] act_sign_total,
    input wire logic [2:0] act_sign_fund,
    input wire logic [2:0] react_sign_total,
    input wire logic [2:0] react_sign_fund,
    // Per-source pulse requests and summed signs, indexed by select code
    input wire logic [7:0] pulse_src_req,
    input wire logic [7:0] pulse_src_sign,
    // Periodic computation finished
    input wire logic dsp_done,
    // Pulse pins, active low
    output logic pulse_output_one_n,
    output logic pulse_output_two_n,
    output logic pulse_output_three_n,
    // Interrupt
    output logic irq
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [PEAK_VAL_W-1:0] peak_val_reg;
    logic [2:0] peak_tag_reg;
    logic [STATUS_W-1:0] status_reg;
    logic [STATUS_W-1:0] status_next;
    logic [STATUS_W-1:0] mask_reg;
    logic [PULSE_MODE_W-1:0] pulse_mode_reg;
    logic [MEAS_MODE_W-1:0] meas_mode_reg;
    logic [SIGN_W-1:0] sign_reg;
    logic [HALF_CYC_W-1:0] half_cyc_reg;
    logic [HALF_CYC_W-1:0] lc_cnt_reg;
    logic [14:0] energy_prev_reg;
    logic [15:0] low_cnt_reg [3];
    logic [31:0] prdata_reg;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire hit_peak = paddr == byte_addr(IDX_PEAK_CAP);
    wire hit_status = paddr == byte_addr(IDX_STATUS);
    wire hit_mask = paddr == byte_addr(IDX_MASK);
    wire hit_pulse_mode = paddr == byte_addr(IDX_PULSE_MODE);
    wire hit_meas_mode = paddr == byte_addr(IDX_MEAS_MODE);
    wire hit_sign = paddr == byte_addr(IDX_SIGN);
    wire hit_half_cyc = paddr == byte_addr(IDX_HALF_CYC);
    wire hit_any = hit_peak | hit_status | hit_mask | hit_pulse_mode
                 | hit_meas_mode | hit_sign | hit_half_cyc;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire wr_en = psel & penable & pwrite & hit_any;

    // Zero wait states keep the host APB interface simple
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = prdata_reg;

    // Read data is captured in the setup cycle, so the access phase needs no wait
    wire [31:0] peak_word = {5'b00000, peak_tag_reg, peak_val_reg};
    wire [31:0] status_word = {13'h0000, status_reg};
    wire [31:0] rd_data =
        hit_peak ? peak_word :
        hit_status ? status_word :
        hit_mask ? {13'h0000, mask_reg} :
        hit_pulse_mode ? {20'h0_0000, pulse_mode_reg} :
        hit_meas_mode ? {29'h0000_0000, meas_mode_reg} :
        hit_sign ? {23'h00_0000, sign_reg} :
        hit_half_cyc ? {16'h0000, half_cyc_reg} : RST_ZERO;

    // ----------------------------------------
    // Sign selection
    // ----------------------------------------
    wire [2:0] act_sign = meas_mode_reg[MM_ACT_SEL] ? act_sign_fund : act_sign_total;
    wire [2:0] react_sign = meas_mode_reg[MM_REACT_SEL] ? react_sign_fund : react_sign_total;
    wire [2:0] sel_one = pulse_mode_reg[PM_SEL_ONE_LSB +: 3];
    wire [2:0] sel_two = pulse_mode_reg[PM_SEL_TWO_LSB +: 3];
    wire [2:0] sel_three = pulse_mode_reg[PM_SEL_THREE_LSB +: 3];
    wire [SIGN_W-1:0] sign_next = {pulse_src_sign[sel_three], pulse_src_sign[sel_two], react_sign,
                                   pulse_src_sign[sel_one], act_sign};
    // Any bit that differs from last cycle's sign is a reversal
    wire [SIGN_W-1:0] sign_flip = sign_next ^ sign_reg;

    // ----------------------------------------
    // Pulse outputs
    // ----------------------------------------
    wire [2:0] src_req = {pulse_src_req[sel_three], pulse_src_req[sel_two], pulse_src_req[sel_one]};
    logic [2:0] pulse_low;
    logic [2:0] pulse_start;
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            pulse_low[k] = low_cnt_reg[k] != 16'h0000;
            pulse_start[k] = src_req[k] & ~pulse_low[k];
        end
    end
    // A disabled pin stays high, but the internal pulse still runs
    wire [2:0] pin_low = pulse_low & ~pulse_mode_reg[CF_DIS_LSB +: 3];
    assign pulse_output_one_n = ~pin_low[0];
    assign pulse_output_two_n = ~pin_low[1];
    assign pulse_output_three_n = ~pin_low[2];

    // ----------------------------------------
    // Line cycle accumulation
    // ----------------------------------------
    // The counter restarts while the mode is off, so a later enable opens a fresh window
    wire line_mode = meas_mode_reg[MM_LINE_MODE];
    wire lc_done = line_mode & half_cycle_tick & (lc_cnt_reg + 16'h0001 >= half_cyc_reg);

    // ----------------------------------------
    // Event collection
    // ----------------------------------------
    wire [14:0] energy_chg = energy_bit30 ^ energy_prev_reg;
    logic [STATUS_W-1:0] ev;
    always_comb
    begin
        ev = '0;
        for (int c = 0; c < 5; c++)
        begin
            ev[c] = |energy_chg[3*c +: 3];
        end
        ev[ST_LINE_DONE] = lc_done;
        ev[ST_ACT_REV_LSB +: 3] = sign_flip[2:0];
        ev[ST_SUM_ONE] = sign_flip[3];
        ev[ST_REACT_REV_LSB +: 3] = sign_flip[6:4];
        ev[ST_SUM_TWO] = sign_flip[7];
        ev[ST_PULSE_LSB +: 3] = pulse_start;
        ev[ST_DONE] = dsp_done;
        ev[ST_SUM_THREE] = sign_flip[8];
    end

    // Set wins over a clear in the same cycle, so no event is lost
    wire [STATUS_W-1:0] clr = (wr_en & hit_status) ? pwdata[STATUS_W-1:0] : '0;
    assign status_next = (status_reg & ~clr) | ev;
    assign irq = |(status_reg & mask_reg);

    // ----------------------------------------
    // Status and read data
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= '0;
            prdata_reg <= RST_ZERO;
        end
        else
        begin
            status_reg <= status_next;
            if (setup_rd)
                prdata_reg <= rd_data;
        end
    end

    // ----------------------------------------
    // Peak capture
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            peak_val_reg <= '0;
            peak_tag_reg <= '0;
        end
        else if (peak_valid)
        begin
            peak_val_reg <= peak_value;
            peak_tag_reg <= peak_phase;
        end
    end

    // ----------------------------------------
    // Configuration
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_reg <= '0;
        else if (wr_en && hit_mask)
            mask_reg <= pwdata[STATUS_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_mode_reg <= '0;
        else if (wr_en && hit_pulse_mode)
            pulse_mode_reg <= pwdata[PULSE_MODE_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            meas_mode_reg <= '0;
        else if (wr_en && hit_meas_mode)
            meas_mode_reg <= pwdata[MEAS_MODE_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_cyc_reg <= RST_HALF_CYC;
        else if (wr_en && hit_half_cyc)
            half_cyc_reg <= pwdata[HALF_CYC_W-1:0];
    end

    // ----------------------------------------
    // Sign and energy history, line cycle counter
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sign_reg <= '0;
            energy_prev_reg <= '0;
        end
        else
        begin
            sign_reg <= sign_next;
            energy_prev_reg <= energy_bit30;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lc_cnt_reg <= '0;
        else if (!line_mode || lc_done)
            lc_cnt_reg <= '0;
        else if (half_cycle_tick)
            lc_cnt_reg <= lc_cnt_reg + 16'h0001;
    end

    // ----------------------------------------
    // Pulse counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < 3; k++)
                low_cnt_reg[k] <= '0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                if (pulse_start[k])
                    low_cnt_reg[k] <= 16'(PULSE_LOW_CYCLES);
                else if (pulse_low[k])
                    low_cnt_reg[k] <= low_cnt_reg[k] - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Peak register
    peak_capture_a: assert property (peak_valid |=> peak_word[23:0] == $past(peak_value))
        else $error("peak value not captured");

    peak_tag_a: assert property (peak_valid |=> peak_tag_reg == $past(peak_phase))
        else $error("peak phase tag not captured");

    peak_upper_a: assert property (peak_word[31:27] == 5'b00000)
        else $error("peak upper bits not zero");

    // Energy half flags, one per accumulator class
    energy_flag_a: assert property ($changed(energy_bit30[2:0]) |-> ##1 status_reg[0])
        else $error("energy half flag missed");

    fund_energy_a: assert property ($changed(energy_bit30[5:3]) |=> status_reg[1])
        else $error("fundamental active half flag missed");

    react_energy_a: assert property ($changed(energy_bit30[8:6]) |=> status_reg[2])
        else $error("reactive half flag missed");

    fund_react_a: assert property ($changed(energy_bit30[11:9]) |=> status_reg[3])
        else $error("fundamental reactive half flag missed");

    apparent_energy_a: assert property ($changed(energy_bit30[14:12]) |=> status_reg[4])
        else $error("apparent half flag missed");

    line_done_a: assert property (lc_done |=> status_reg[ST_LINE_DONE])
        else $error("line cycle flag missed");

    // Reversals and reported signs
    act_rev_a: assert property ($changed(act_sign) |=> |status_reg[ST_ACT_REV_LSB +: 3])
        else $error("active reversal flag missed");

    react_rev_a: assert property ($changed(react_sign) |=> |status_reg[ST_REACT_REV_LSB +: 3])
        else $error("reactive reversal flag missed");

    sum_rev_a: assert property (sign_flip[3] |=> status_reg[ST_SUM_ONE])
        else $error("sum reversal flag missed");

    sum_two_rev_a: assert property (sign_flip[7] |=> status_reg[ST_SUM_TWO])
        else $error("second sum reversal flag missed");

    sum_three_rev_a: assert property (sign_flip[8] |=> status_reg[ST_SUM_THREE])
        else $error("third sum reversal flag missed");

    act_sign_a: assert property (1'b1 |=> sign_reg[2:0] == $past(act_sign))
        else $error("active sign not reported");

    react_sign_a: assert property (1'b1 |=> sign_reg[6:4] == $past(react_sign))
        else $error("reactive sign not reported");

    // Pulse outputs
    pulse_flag_a: assert property ($rose(pulse_low[0]) |-> status_reg[ST_PULSE_LSB])
        else $error("pulse flag missed");

    pulse_two_flag_a: assert property ($rose(pulse_low[1]) |-> status_reg[ST_PULSE_LSB + 1])
        else $error("second pulse flag missed");

    pulse_three_flag_a: assert property ($rose(pulse_low[2]) |-> status_reg[ST_PULSE_LSB + 2])
        else $error("third pulse flag missed");

    pulse_width_a: assert property (pulse_start[0] |=> low_cnt_reg[0] == 16'(PULSE_LOW_CYCLES))
        else $error("pulse width not loaded");

    pulse_disabled_a: assert property (pulse_mode_reg[CF_DIS_LSB] |-> pulse_output_one_n)
        else $error("disabled pulse pin went low");

    pulse_two_off_a: assert property (pulse_mode_reg[CF_DIS_LSB + 1] |-> pulse_output_two_n)
        else $error("disabled second pulse pin went low");

    pulse_three_off_a: assert property (pulse_mode_reg[CF_DIS_LSB + 2] |-> pulse_output_three_n)
        else $error("disabled third pulse pin went low");

    // Done flag, reserved bits and clearing
    done_flag_a: assert property (dsp_done |=> status_reg[ST_DONE])
        else $error("compute done flag missed");

    status_upper_a: assert property (status_word[31:19] == 13'h0000)
        else $error("status upper bits not zero");

    flag_sticky_a: assert property (status_reg[0] && !clr[0] |=> status_reg[0])
        else $error("flag dropped without clear");

    flag_clear_a: assert property (wr_en && hit_status && pwdata[0] && !ev[0] |=> !status_reg[0])
        else $error("flag not cleared by write");

    clear_cov: cover property (wr_en && hit_status && |(status_reg & pwdata[STATUS_W-1:0]));
    sign_cov: cover property (|sign_flip);
    pulse_cov: cover property (pulse_start[1] ##1 pulse_low[1] [*3]);
    irq_cov: cover property (!irq ##1 irq);
    line_cov: cover property (line_mode && lc_done);

endmodule
`default_nettype wire
